/* File: hdl/spes_pkg.sv */
/*
 * constants of the serial port status and control register bank.
 * assumes byte addressing on a 32-bit avalon-mm slave port.
 */
package spes_pkg;
    localparam int          NUM_PORTS    = 4;
    localparam int          BE_W         = 4;

    // port control registers, one per port
    localparam logic [15:0] CTL_OFS [4]  = '{16'h115C, 16'h117C,
                                             16'h119C, 16'h11BC};
    // port error and status registers, one per port
    localparam logic [15:0] ERR_OFS [4]  = '{16'h1158, 16'h1178,
                                             16'h1198, 16'h11B8};
    // bank-level registers
    localparam logic [15:0] MODE_OFS     = 16'h1000;
    localparam logic [15:0] IRQ_STAT_OFS = 16'h1004;
    localparam logic [15:0] IRQ_MASK_OFS = 16'h1008;

    // error and status field positions
    localparam int B_OUT_RETRY_SEEN = 20;
    localparam int B_OUT_RETRIED    = 19;
    localparam int B_OUT_RETRY_STP  = 18;
    localparam int B_OUT_ERR_SEEN   = 17;
    localparam int B_OUT_ERR_STP    = 16;
    localparam int B_IN_RETRY_STP   = 10;
    localparam int B_IN_ERR_SEEN    = 9;
    localparam int B_IN_ERR_STP     = 8;
    localparam int B_MAINT_PND      = 4;
    localparam int B_PORT_ERR       = 2;
    localparam int B_PORT_OK        = 1;
    localparam int B_UNINIT         = 0;

    // control field positions
    localparam int B_HW_WIDTH_LO    = 30;
    localparam int B_INIT_WIDTH_LO  = 27;

    // hardware width codes
    localparam logic [1:0] HW_W_1LANE   = 2'h0;
    localparam logic [1:0] HW_W_4LANE   = 2'h1;
    // initialized width codes
    localparam logic [2:0] INIT_W_LANE0 = 3'h0;
    localparam logic [2:0] INIT_W_LANE2 = 3'h1;
    localparam logic [2:0] INIT_W_4LANE = 3'h2;

    // mode register fields and reset value
    localparam int B_SINGLE_LANE_SEL    = 0;
    localparam int B_PORT_MODE_LO       = 1;
    localparam logic [1:0] PMODE_SINGLE = 2'h0;
    localparam logic [1:0] PMODE_MULTI  = 2'h1;
    localparam logic [2:0] MODE_RST     = 3'h0;

    // interrupt status layout: four events per port
    localparam int EV_PER_PORT      = 4;
endpackage : spes_pkg

/* File: hdl/spes_port_status.sv */
/*
 * error and status flags of one serial port.
 * assumes link-side inputs come from logic on the same clock.
 */
module spes_port_status (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // link-side events and states
    input  wire logic        retry_sym_in,
    input  wire logic        ack_sym_in,
    input  wire logic        out_err_stop_in,
    input  wire logic        in_retry_stop_in,
    input  wire logic        in_err_stop_in,
    input  wire logic        maint_wr_req_in,
    input  wire logic        unrecov_in,
    input  wire logic        init_in,
    input  wire logic        sym_ok_in,
    // write-one-to-clear mask, zero outside a taken write
    input  wire logic [31:0] w1c_in,
    // status word and set events
    output logic      [31:0] stat_out,
    output logic      [3:0]  event_out
);
    logic out_retry_stopped_ff;
    logic out_retried_ff;
    logic out_retry_seen_ff;
    logic out_error_stopped_ff;
    logic out_tx_error_seen_ff;
    logic in_retry_stopped_ff;
    logic in_error_stopped_ff;
    logic in_tx_error_seen_ff;
    logic maint_write_pending_ff;
    logic port_err_ff;
    logic port_ok_ff;
    logic uninit_ff;
    logic set_retry_seen;
    logic set_out_err;
    logic set_in_err;

    // rising edges of the stopped states
    assign set_retry_seen = retry_sym_in & ~out_retry_stopped_ff;
    assign set_out_err    = out_err_stop_in & ~out_error_stopped_ff;
    assign set_in_err     = in_err_stop_in & ~in_error_stopped_ff;

    // output retry-stopped state and retried flag
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            out_retry_stopped_ff <= 1'b0;
            out_retried_ff       <= 1'b0;
        end else if (retry_sym_in) begin
            out_retry_stopped_ff <= 1'b1; // [R1]
            out_retried_ff       <= 1'b1; // [R17]
        end else if (ack_sym_in) begin
            out_retry_stopped_ff <= 1'b0; // [R1]
            out_retried_ff       <= 1'b0; // [R17]
        end
    end

    // mirrored stopped states
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            out_error_stopped_ff <= 1'b0;
            in_retry_stopped_ff  <= 1'b0;
            in_error_stopped_ff  <= 1'b0;
        end else begin
            out_error_stopped_ff <= out_err_stop_in;  // [R3]
            in_retry_stopped_ff  <= in_retry_stop_in; // [R4]
            in_error_stopped_ff  <= in_err_stop_in;   // [R6]
        end
    end

    // sticky flags, a set beats a same-cycle clear
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            out_retry_seen_ff      <= 1'b0;
            out_tx_error_seen_ff   <= 1'b0;
            in_tx_error_seen_ff    <= 1'b0;
            maint_write_pending_ff <= 1'b0;
            port_err_ff            <= 1'b0;
        end else begin
            out_retry_seen_ff <= (out_retry_seen_ff & // [R18] [R19]
                ~w1c_in[spes_pkg::B_OUT_RETRY_SEEN]) | set_retry_seen;
            out_tx_error_seen_ff <= (out_tx_error_seen_ff & // [R2] [R19]
                ~w1c_in[spes_pkg::B_OUT_ERR_SEEN]) | set_out_err;
            in_tx_error_seen_ff <= (in_tx_error_seen_ff & // [R5] [R19]
                ~w1c_in[spes_pkg::B_IN_ERR_SEEN]) | set_in_err;
            maint_write_pending_ff <= (maint_write_pending_ff & // [R8]
                ~w1c_in[spes_pkg::B_MAINT_PND]) | maint_wr_req_in;
            port_err_ff <= (port_err_ff & // [R9] [R19]
                ~w1c_in[spes_pkg::B_PORT_ERR]) | unrecov_in;
        end
    end

    // port ok and uninitialized, never both high
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            port_ok_ff <= 1'b0;
            uninit_ff  <= 1'b1;
        end else begin
            port_ok_ff <= init_in & sym_ok_in; // [R10]
            uninit_ff  <= ~init_in;            // [R11]
        end
    end

    // status word, reserved bits stay zero
    always_comb begin
        stat_out = '0; // [R7]
        stat_out[spes_pkg::B_OUT_RETRY_SEEN] = out_retry_seen_ff;
        stat_out[spes_pkg::B_OUT_RETRIED]    = out_retried_ff;
        stat_out[spes_pkg::B_OUT_RETRY_STP]  = out_retry_stopped_ff;
        stat_out[spes_pkg::B_OUT_ERR_SEEN]   = out_tx_error_seen_ff;
        stat_out[spes_pkg::B_OUT_ERR_STP]    = out_error_stopped_ff;
        stat_out[spes_pkg::B_IN_RETRY_STP]   = in_retry_stopped_ff;
        stat_out[spes_pkg::B_IN_ERR_SEEN]    = in_tx_error_seen_ff;
        stat_out[spes_pkg::B_IN_ERR_STP]     = in_error_stopped_ff;
        stat_out[spes_pkg::B_MAINT_PND]      = maint_write_pending_ff;
        stat_out[spes_pkg::B_PORT_ERR]       = port_err_ff;
        stat_out[spes_pkg::B_PORT_OK]        = port_ok_ff;
        stat_out[spes_pkg::B_UNINIT]         = uninit_ff;
    end

    // events that raise interrupt status bits
    assign event_out = {unrecov_in, maint_wr_req_in, set_in_err, set_out_err};
endmodule // spes_port_status

/* File: hdl/spes_regs.sv */
/*
 * status, width and interrupt registers of four serial ports.
 * assumes avalon-mm with waitrequest; link inputs on CLK_IN.
 */
// How it works
// R1 - output retry-stopped flag follows retry state
// R2 - output error seen sticks on error-stop
// R3 - output error-stopped flag mirrors output state
// R4 - input retry-stopped flag mirrors input state
// R5 - input error seen sticks on error-stop
// R6 - input error-stopped flag mirrors input state
// R7 - reserved status bits always read zero
// R8 - port-write pending sticks until written one
// R9 - unrecoverable error sticks until written one
// R10 - port ok needs init and clean symbols
// R11 - uninitialized flag never with port ok
// R12 - four control registers at fixed offsets
// R13 - multi-port mode allows single lane only
// R14 - single-port mode: four lanes or one
// R15 - hardware width field encodes lane capability
// R16 - initialized width field reports trained width
// R17 - retried flag clears on accept symbols
// R18 - output retry seen sticks on retry-stop
// R19 - set beats same-cycle software clear
module spes_regs (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    // avalon-mm slave
    input  wire logic [15:0] AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    // per-port link events, one bit per port
    input  wire logic [3:0]  RETRY_SYM_IN,
    input  wire logic [3:0]  ACK_SYM_IN,
    input  wire logic [3:0]  OUT_ERR_STOP_IN,
    input  wire logic [3:0]  IN_RETRY_STOP_IN,
    input  wire logic [3:0]  IN_ERR_STOP_IN,
    input  wire logic [3:0]  MAINT_WR_REQ_IN,
    input  wire logic [3:0]  UNRECOV_ERR_IN,
    input  wire logic [3:0]  PORT_INIT_IN,
    input  wire logic [3:0]  SYM_OK_IN,
    // trained width of port 0 in single-port mode
    input  wire logic [2:0]  TRAINED_WIDTH_IN,
    // interrupt
    output logic             IRQ_OUT
);
    localparam int NP = spes_pkg::NUM_PORTS;
    localparam int EP = spes_pkg::EV_PER_PORT;

    logic                     wait_ff;
    logic [31:0]              rdata_ff;
    logic [31:0]              nxt_rdata;
    logic                     irq_ff;
    logic [2:0]               mode_ff;
    logic [15:0]              irq_stat_ff;
    logic [15:0]              irq_mask_ff;
    logic                     req;
    logic                     take_wr;
    logic [31:0]              wmask;
    logic                     multi_port;
    logic [31:0]              stat_word [4];
    logic [31:0]              ctl_word  [4];
    logic [31:0]              w1c       [4];
    logic [15:0]              irq_set;
    logic [2:0]               legal_width;

    // bus request and write acceptance
    assign req     = AVS_READ_IN | AVS_WRITE_IN;
    assign take_wr = AVS_WRITE_IN & ~wait_ff;

    // write data gated by the byte enables into a bit mask
    always_comb begin
        wmask = '0;
        for (int b = 0; b < spes_pkg::BE_W; b++) begin
            if (AVS_BYTEENABLE_IN[b]) begin
                wmask[b*8 +: 8] = AVS_WRITEDATA_IN[b*8 +: 8];
            end
        end
    end

    // wait state: one cycle of waitrequest high, then one low
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            wait_ff <= 1'b1;
        end else if (req && wait_ff) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    // read data captured when the request is first seen
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            rdata_ff <= '0;
        end else if (AVS_READ_IN && wait_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // port mode register: single-lane select and port mode select
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            mode_ff <= spes_pkg::MODE_RST;
        end else if (take_wr && AVS_ADDRESS_IN == spes_pkg::MODE_OFS
                     && AVS_BYTEENABLE_IN[0]) begin
            mode_ff <= AVS_WRITEDATA_IN[2:0];
        end
    end

    // multi-port mode only with select 1 and mode 01
    assign multi_port =
        mode_ff[spes_pkg::B_SINGLE_LANE_SEL] &&
        mode_ff[spes_pkg::B_PORT_MODE_LO +: 2] == spes_pkg::PMODE_MULTI;

    // trained width filtered to legal codes
    always_comb begin
        case (TRAINED_WIDTH_IN)
            spes_pkg::INIT_W_LANE0: legal_width = spes_pkg::INIT_W_LANE0;
            spes_pkg::INIT_W_LANE2: legal_width = spes_pkg::INIT_W_LANE2;
            spes_pkg::INIT_W_4LANE: legal_width = spes_pkg::INIT_W_4LANE;
            default:                legal_width = spes_pkg::INIT_W_LANE0;
        endcase
    end

    // per-port status blocks and control words
    generate
        for (genvar p = 0; p < NP; p++) begin : g_port
            // clear mask only for a taken write to this port's status
            assign w1c[p] = (take_wr &&
                AVS_ADDRESS_IN == spes_pkg::ERR_OFS[p]) ? wmask : '0;

            spes_port_status u_stat (
                .clk_in           (CLK_IN),
                .srst_in          (SRST_IN),
                .retry_sym_in     (RETRY_SYM_IN[p]),
                .ack_sym_in       (ACK_SYM_IN[p]),
                .out_err_stop_in  (OUT_ERR_STOP_IN[p]),
                .in_retry_stop_in (IN_RETRY_STOP_IN[p]),
                .in_err_stop_in   (IN_ERR_STOP_IN[p]),
                .maint_wr_req_in  (MAINT_WR_REQ_IN[p]),
                .unrecov_in       (UNRECOV_ERR_IN[p]),
                .init_in          (PORT_INIT_IN[p]),
                .sym_ok_in        (SYM_OK_IN[p]),
                .w1c_in           (w1c[p]),
                .stat_out         (stat_word[p]),
                .event_out        (irq_set[p*EP +: EP])
            );

            // width fields; other control bits read zero
            always_comb begin
                ctl_word[p] = '0;
                if (p == 0 && !multi_port) begin
                    // four-lane capable only on port 0 [R15] [R14]
                    ctl_word[p][spes_pkg::B_HW_WIDTH_LO +: 2] =
                        spes_pkg::HW_W_4LANE;
                    ctl_word[p][spes_pkg::B_INIT_WIDTH_LO +: 3] =
                        legal_width; // [R16] [R14]
                end else begin
                    // single lane on lane 0 only [R13] [R15] [R16]
                    ctl_word[p][spes_pkg::B_HW_WIDTH_LO +: 2] =
                        spes_pkg::HW_W_1LANE;
                    ctl_word[p][spes_pkg::B_INIT_WIDTH_LO +: 3] =
                        spes_pkg::INIT_W_LANE0;
                end
            end
        end
    endgenerate

    // interrupt mask register
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            irq_mask_ff <= '0;
        end else if (take_wr &&
                     AVS_ADDRESS_IN == spes_pkg::IRQ_MASK_OFS) begin
            irq_mask_ff <= wmask[15:0] |
                (irq_mask_ff & ~{{8{AVS_BYTEENABLE_IN[1]}},
                                 {8{AVS_BYTEENABLE_IN[0]}}});
        end
    end

    // interrupt status: events set, write one clears, set wins
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            irq_stat_ff <= '0;
        end else if (take_wr &&
                     AVS_ADDRESS_IN == spes_pkg::IRQ_STAT_OFS) begin
            irq_stat_ff <= (irq_stat_ff & ~wmask[15:0]) | irq_set; // [R19]
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        nxt_rdata = '0;
        case (AVS_ADDRESS_IN)
            spes_pkg::MODE_OFS:     nxt_rdata[2:0]  = mode_ff;
            spes_pkg::IRQ_STAT_OFS: nxt_rdata[15:0] = irq_stat_ff;
            spes_pkg::IRQ_MASK_OFS: nxt_rdata[15:0] = irq_mask_ff;
            default:                nxt_rdata       = '0;
        endcase
        for (int p = 0; p < NP; p++) begin
            if (AVS_ADDRESS_IN == spes_pkg::ERR_OFS[p]) begin
                nxt_rdata = stat_word[p];
            end
            if (AVS_ADDRESS_IN == spes_pkg::CTL_OFS[p]) begin
                nxt_rdata = ctl_word[p]; // [R12]
            end
        end
    end

    // outputs straight from flip-flops
    assign AVS_READDATA_OUT    = rdata_ff;
    assign AVS_WAITREQUEST_OUT = wait_ff;
    assign IRQ_OUT             = irq_ff;
endmodule // spes_regs

/* File: testbench/spes_link_partner.sv */
/*
 * link partner model: symbols, states, requests, port 0 width.
 * assumes tasks are called after a rising edge.
 */
module spes_link_partner (
    // clock
    input  wire logic       clk_in,
    // symbols, states and requests, one bit per port
    output logic      [3:0] retry_sym_out,
    output logic      [3:0] ack_sym_out,
    output logic      [3:0] out_err_stop_out,
    output logic      [3:0] in_retry_stop_out,
    output logic      [3:0] in_err_stop_out,
    output logic      [3:0] maint_wr_req_out,
    output logic      [3:0] unrecov_err_out,
    output logic      [3:0] port_init_out,
    output logic      [3:0] sym_ok_out,
    // trained width of port 0
    output logic      [2:0] trained_width_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // link quiet and untrained at start
    logic [3:0] st_ff [9] = '{default: 4'h0};
    logic [2:0] width_ff  = 3'h0;

    // one row per line kind fans out to the ports
    assign {sym_ok_out, port_init_out, unrecov_err_out, maint_wr_req_out,
            in_err_stop_out, in_retry_stop_out, out_err_stop_out,
            ack_sym_out, retry_sym_out} = {st_ff[8], st_ff[7], st_ff[6],
            st_ff[5], st_ff[4], st_ff[3], st_ff[2], st_ff[1], st_ff[0]};
    assign trained_width_out = width_ff;

    // set one line of one port from this edge on
    task automatic drive(input int k, input int p, input logic v);
        st_ff[k][p] <= v;
    endtask
    // one-cycle pulse on one line
    task automatic pulse(input int k, input int p);
        drive(k, p, 1'b1);
        @(posedge clk_in);
        drive(k, p, 1'b0);
    endtask
    // report a new trained width
    task automatic width(input logic [2:0] w);
        width_ff <= w;
    endtask
endmodule // spes_link_partner

/* File: testbench/spes_regs_chk.sv */
/*
 * checker for spes_regs: bus handshake, port 0 status, control words.
 * assumes it is bound to spes_regs and sees only its ports.
 */
module spes_regs_chk (
    // clock and reset
    input wire logic        CLK_IN,
    input wire logic        SRST_IN,
    // avalon-mm slave
    input wire logic [15:0] AVS_ADDRESS_IN,
    input wire logic        AVS_READ_IN,
    input wire logic        AVS_WRITE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic        AVS_WAITREQUEST_OUT,
    // link lines
    input wire logic [3:0]  RETRY_SYM_IN,
    input wire logic [3:0]  ACK_SYM_IN,
    input wire logic [3:0]  OUT_ERR_STOP_IN,
    input wire logic [3:0]  IN_RETRY_STOP_IN,
    input wire logic [3:0]  IN_ERR_STOP_IN,
    input wire logic [3:0]  PORT_INIT_IN,
    input wire logic [3:0]  SYM_OK_IN
);
    localparam logic [31:0] STICKY = 32'h0012_0214;
    logic        rq, rd0, rd0_end, ctl0, ctl_hi, ok0, ini0, seen_ff;
    logic [2:0]  lvl0;
    logic [31:0] prev_ff;

    // request decodes
    assign rq      = AVS_READ_IN && AVS_WAITREQUEST_OUT;
    assign rd0     = rq && AVS_ADDRESS_IN == spes_pkg::ERR_OFS[0];
    assign rd0_end = AVS_READ_IN && !AVS_WAITREQUEST_OUT
                     && AVS_ADDRESS_IN == spes_pkg::ERR_OFS[0];
    assign ctl0    = rq && AVS_ADDRESS_IN == spes_pkg::CTL_OFS[0];
    assign ctl_hi  = rq && AVS_ADDRESS_IN inside {spes_pkg::CTL_OFS[1],
                     spes_pkg::CTL_OFS[2], spes_pkg::CTL_OFS[3]};
    assign ok0     = PORT_INIT_IN[0] && SYM_OK_IN[0];
    assign ini0    = PORT_INIT_IN[0];
    assign lvl0    = {OUT_ERR_STOP_IN[0], IN_RETRY_STOP_IN[0],
                      IN_ERR_STOP_IN[0]};

    // last port 0 status read; a write voids it
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT)) begin
            seen_ff <= 1'b0;
        end else if (rd0_end) begin
            seen_ff <= 1'b1;
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (rd0_end) begin
            prev_ff <= AVS_READDATA_OUT;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);

    sequence s_req;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
    endsequence
    sequence s_one_wait;
        !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
    endsequence
    sequence s_retry0;
        RETRY_SYM_IN[0] ##1 rd0 && !ACK_SYM_IN[0];
    endsequence
    sequence s_ack0;
        ACK_SYM_IN[0] && !RETRY_SYM_IN[0] ##1 rd0 && !RETRY_SYM_IN[0];
    endsequence

    AST_ONE_WAIT: assert property (s_req |=> s_one_wait)
        else $error("wait not one cycle");
    AST_RSVD_ZERO: assert property (
        rd0 |=> (AVS_READDATA_OUT & 32'h0000_F8E8) == 32'h0)
        else $error("reserved bits set");
    AST_PORT_OK: assert property (
        rd0 && ok0 && $past(ok0) && $past(ok0, 2)
        |=> AVS_READDATA_OUT[1:0] == 2'b10)
        else $error("port ok wrong");
    AST_UNINIT: assert property (
        rd0 && !ini0 && !$past(ini0) && !$past(ini0, 2)
        |=> AVS_READDATA_OUT[1:0] == 2'b01)
        else $error("uninit wrong");
    AST_STATE_MIRROR: assert property (
        rd0 && lvl0 == $past(lvl0) && lvl0 == $past(lvl0, 2)
        |=> {AVS_READDATA_OUT[16], AVS_READDATA_OUT[10],
             AVS_READDATA_OUT[8]} == $past(lvl0))
        else $error("state flags wrong");
    AST_RETRY_SET: assert property (
        s_retry0 |=> AVS_READDATA_OUT[20:18] == 3'b111)
        else $error("retry set wrong");
    AST_RETRY_CLR: assert property (
        s_ack0 |=> AVS_READDATA_OUT[19:18] == 2'b00)
        else $error("retry clear wrong");
    AST_STICKY_HOLD: assert property (
        rd0_end && seen_ff
        |-> (AVS_READDATA_OUT & prev_ff & STICKY) == (prev_ff & STICKY))
        else $error("sticky bit lost");
    AST_CTL_UPPER: assert property (
        ctl_hi |=> AVS_READDATA_OUT == 32'h0)
        else $error("ctl 1-3 nonzero");
    AST_CTL0_CODES: assert property (
        ctl0 |=> AVS_READDATA_OUT[26:0] == 27'h0 && !AVS_READDATA_OUT[31]
        && AVS_READDATA_OUT[29:27] inside {3'h0, 3'h1, 3'h2})
        else $error("ctl0 code bad");
endmodule // spes_regs_chk

bind spes_regs spes_regs_chk u_chk (.*);

/* File: testbench/spes_regs_tb.sv */
/*
 * bench for spes_regs, one task per scenario.
 * assumes the link partner model and the bound checker.
 */
module spes_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LVL [5] = '{2, 3, 4, 7, 8};
    logic        clk, srst, avs_read, avs_write, avs_waitrequest, irq;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable, retry_sym, ack_sym, out_err_stop;
    logic [3:0]  in_retry_stop, in_err_stop, maint_wr_req, unrecov_err;
    logic [3:0]  port_init, sym_ok;
    logic [2:0]  trained_width;
    int          err_total, comparisons;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    spes_regs dut (.CLK_IN(clk), .SRST_IN(srst),
        .AVS_ADDRESS_IN(avs_address), .AVS_READ_IN(avs_read),
        .AVS_WRITE_IN(avs_write), .AVS_WRITEDATA_IN(avs_writedata),
        .AVS_BYTEENABLE_IN(avs_byteenable), .AVS_READDATA_OUT(avs_readdata),
        .AVS_WAITREQUEST_OUT(avs_waitrequest), .RETRY_SYM_IN(retry_sym),
        .ACK_SYM_IN(ack_sym), .OUT_ERR_STOP_IN(out_err_stop),
        .IN_RETRY_STOP_IN(in_retry_stop), .IN_ERR_STOP_IN(in_err_stop),
        .MAINT_WR_REQ_IN(maint_wr_req), .UNRECOV_ERR_IN(unrecov_err),
        .PORT_INIT_IN(port_init), .SYM_OK_IN(sym_ok),
        .TRAINED_WIDTH_IN(trained_width), .IRQ_OUT(irq));
    spes_link_partner lnk (.clk_in(clk), .retry_sym_out(retry_sym),
        .ack_sym_out(ack_sym), .out_err_stop_out(out_err_stop),
        .in_retry_stop_out(in_retry_stop), .in_err_stop_out(in_err_stop),
        .maint_wr_req_out(maint_wr_req), .unrecov_err_out(unrecov_err),
        .port_init_out(port_init), .sym_ok_out(sym_ok),
        .trained_width_out(trained_width));

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        check({31'h0, avs_waitrequest}, 32'h0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask
    function automatic logic [15:0] err(input int p);
        return spes_pkg::ERR_OFS[p];
    endfunction

    // reset values and an unmapped address
    task automatic t_reset_vals();
        for (int p = 0; p < 4; p++) rdc(err(p), 32'h1);
        rdc(spes_pkg::MODE_OFS, 32'h0);
        rdc(spes_pkg::IRQ_MASK_OFS, 32'h0);
        rdc(16'h1010, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask
    // width fields in both port modes
    task automatic t_widths();
        for (int w = 0; w < 3; w++) begin
            lnk.width(w[2:0]);
            rdc(spes_pkg::CTL_OFS[0],
                {spes_pkg::HW_W_4LANE, w[2:0], 27'h0});
        end
        for (int p = 1; p < 4; p++) rdc(spes_pkg::CTL_OFS[p], 32'h0);
        wr(spes_pkg::CTL_OFS[0], 32'hFFFF_FFFF);
        rdc(spes_pkg::CTL_OFS[0], 32'h5000_0000);
        wr(spes_pkg::MODE_OFS, 32'h3);
        rdc(spes_pkg::MODE_OFS, 32'h3);
        rdc(spes_pkg::CTL_OFS[0], 32'h0);
        wr(spes_pkg::MODE_OFS, 32'h0);
    endtask
    // link states on every port, then their sticky traces
    task automatic t_levels();
        for (int p = 0; p < 4; p++) begin
            foreach (LVL[i]) lnk.drive(LVL[i], p, 1'b1);
            rdc(err(p), 32'h0003_0702);
            rdc(err(p), 32'h0003_0702);
            foreach (LVL[i]) lnk.drive(LVL[i], p, 1'b0);
            rdc(err(p), 32'h0002_0201);
            rdc(err(p), 32'h0002_0201);
            wr(err(p), 32'hFFFF_FFFF);
            rdc(err(p), 32'h1);
        end
    endtask
    // retry then accept symbol on port 0
    task automatic t_retry();
        fork
            lnk.pulse(0, 0);
            rdc(err(0), 32'h001C_0001);
        join
        fork
            lnk.pulse(1, 0);
            rdc(err(0), 32'h0010_0001);
        join
        wr(err(0), 32'h0010_0000);
        rdc(err(0), 32'h1);
    endtask
    // port-write and unrecoverable error raise, mask and clear irq
    task automatic t_irq();
        wr(spes_pkg::IRQ_STAT_OFS, 32'h0000_FFFF);
        wr(spes_pkg::IRQ_MASK_OFS, 32'h0000_FFFF);
        lnk.pulse(5, 2);
        lnk.pulse(6, 2);
        rdc(err(2), 32'h15);
        rdc(spes_pkg::IRQ_STAT_OFS, 32'h0C00);
        check({31'h0, irq}, 32'h1);
        wr(spes_pkg::IRQ_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(spes_pkg::IRQ_MASK_OFS, 32'h0000_FFFF);
        wr(spes_pkg::IRQ_STAT_OFS, 32'h0400);
        rdc(spes_pkg::IRQ_STAT_OFS, 32'h0800);
        wr(spes_pkg::IRQ_STAT_OFS, 32'h0800);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(err(2), 32'h14);
        rdc(err(2), 32'h1);
    endtask
    // port-write request against its clearing write
    task automatic t_race();
        lnk.drive(5, 3, 1'b1);
        wr(err(3), 32'h10);
        lnk.drive(5, 3, 1'b0);
        rdc(err(3), 32'h11);
    endtask

    // verdict
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        finish_test();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 16'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset_vals();
        t_widths();
        t_levels();
        t_retry();
        t_irq();
        t_race();
        finish_test();
    end
endmodule // spes_regs_tb
